// File: pkg/i2c_port_pkg.sv
// Shared constants and types of the I2C slave register port
package i2c_port_pkg;

    localparam logic [6:0] DEV_ADDR_RST = 7'h2A;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
    localparam logic [6:0] CBUS_ADDR = 7'h01;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_DONE = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [7:0] PTR_TOP = 8'hFF;
    localparam int WR_START_MAX_CYC = 3;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_REG,
        S_WDATA,
        S_GC,
        S_ACK,
        S_TX,
        S_TXACK,
        S_IGNORE
    } slv_state_t;

    typedef struct packed {
        slv_state_t st;
        slv_state_t after_ack;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic [6:0] dev_addr;
        logic sda_oe;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } slv_regs_t;

    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic q;
    } sync_regs_t;

    typedef struct packed {
        logic scl_d;
        logic sda_d;
    } cond_regs_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_evt_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage : i2c_port_pkg

// File: design/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pin_i,
    output logic level_o
);
    i2c_port_pkg::sync_regs_t state_r;
    i2c_port_pkg::sync_regs_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.f1 = pin_i;
        state_nxt.f2 = state_r.f1;
        state_nxt.f3 = state_r.f2;
        // First stage feeds only the second
        if (state_r.f2 == state_r.f3) begin
            state_nxt.q = state_r.f3;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= '{f1: 1'b1, f2: 1'b1, f3: 1'b1, q: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level_o = state_r.q;

endmodule : pin_sync3

// File: design/bus_cond_detect.sv
// Detects SCL edges and START/STOP conditions on filtered lines
`timescale 1ns/100ps
module bus_cond_detect (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_s,
    input wire logic sda_s,
    output i2c_port_pkg::bus_evt_t evt
);
    i2c_port_pkg::cond_regs_t state_r;
    i2c_port_pkg::cond_regs_t state_nxt;

    always_comb begin
        state_nxt.scl_d = scl_s;
        state_nxt.sda_d = sda_s;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= '{scl_d: 1'b1, sda_d: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        evt.scl_rise = scl_s & ~state_r.scl_d;
        evt.scl_fall = ~scl_s & state_r.scl_d;
        // SDA moving while SCL stays high
        evt.start = scl_s & state_r.scl_d & state_r.sda_d & ~sda_s;
        evt.stop = scl_s & state_r.scl_d & ~state_r.sda_d & sda_s;
    end

endmodule : bus_cond_detect

// File: design/i2c_slave_register_port.sv
// I2C slave front end giving a bus master access to the register space
`timescale 1ns/100ps

// Overview of operation
// - First byte: seven address bits plus direction
// - Own address with write: acknowledge, receive
// - Byte after address loads register pointer
// - Data bytes acknowledged, stored, pointer advances
// - Two-byte write only sets the pointer
// - Acknowledge writes to missing registers too
// - Pointer wraps from top to zero
// - Never answer a CBUS address
// - Own address with read: acknowledge, transmit
// - Pointer starts at zero after reset
// - Master ACK continues, NACK releases line
// - Missing register reads complete normally
// - Register write starts within three clocks
// - General call second byte sets address
// - Stored address loaded after power-up
// - Reserved addresses never used as address; general call and stored load accept any value
module i2c_slave_register_port #(
    parameter logic [6:0] DEV_ADDR_DEFAULT = i2c_port_pkg::DEV_ADDR_RST
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic nv_load,
    input wire logic [6:0] nv_dev_addr,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output i2c_port_pkg::reg_wr_t reg_wr,
    output logic [6:0] dev_addr
);
    i2c_port_pkg::slv_regs_t state_r;
    i2c_port_pkg::slv_regs_t state_nxt;
    i2c_port_pkg::bus_evt_t evt;
    logic scl_s;
    logic sda_s;
    logic [7:0] rx_byte;
    logic [6:0] rx_addr;
    logic byte_end;

    pin_sync3 u_scl_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_i(scl_i),
        .level_o(scl_s)
    );

    pin_sync3 u_sda_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_i(sda_i),
        .level_o(sda_s)
    );

    bus_cond_detect u_cond (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .evt(evt)
    );

    // Byte as it stands once the eighth bit is sampled
    assign rx_byte = {state_r.shreg[6:0], sda_s};
    assign rx_addr = rx_byte[7:1];
    assign byte_end = evt.scl_rise && (state_r.bitcnt == i2c_port_pkg::BIT_LAST);

    always_comb begin
        state_nxt = state_r;
        state_nxt.wr_en = 1'b0;
        if (nv_load) begin
            state_nxt.dev_addr = nv_dev_addr;
        end
        if (evt.start) begin
            state_nxt.st = i2c_port_pkg::S_ADDR;
            state_nxt.bitcnt = i2c_port_pkg::BIT_ZERO;
            state_nxt.sda_oe = 1'b0;
        end else if (evt.stop) begin
            state_nxt.st = i2c_port_pkg::S_IDLE;
            state_nxt.sda_oe = 1'b0;
        end else begin
            case (state_r.st)
                i2c_port_pkg::S_ADDR, i2c_port_pkg::S_REG, i2c_port_pkg::S_WDATA, i2c_port_pkg::S_GC: begin
                    if (evt.scl_rise) begin
                        state_nxt.shreg = rx_byte;
                        state_nxt.bitcnt = 4'(state_r.bitcnt + 4'h1);
                    end else if (evt.scl_fall && state_r.bitcnt == i2c_port_pkg::BIT_DONE) begin
                        // Acknowledge driven low through the ninth clock
                        state_nxt.sda_oe = 1'b1;
                        state_nxt.st = i2c_port_pkg::S_ACK;
                    end
                    if (byte_end) begin
                        case (state_r.st)
                            i2c_port_pkg::S_ADDR: begin
                                if (rx_addr == i2c_port_pkg::CBUS_ADDR) begin
                                    state_nxt.st = i2c_port_pkg::S_IGNORE;
                                end else if (rx_byte == i2c_port_pkg::GEN_CALL_BYTE) begin
                                    state_nxt.after_ack = i2c_port_pkg::S_GC;
                                end else if (rx_addr == state_r.dev_addr) begin
                                    state_nxt.after_ack = (rx_byte[0] == i2c_port_pkg::RW_READ) ?
                                        i2c_port_pkg::S_TX : i2c_port_pkg::S_REG;
                                end else begin
                                    state_nxt.st = i2c_port_pkg::S_IGNORE;
                                end
                            end
                            i2c_port_pkg::S_REG: begin
                                state_nxt.ptr = rx_byte;
                                state_nxt.after_ack = i2c_port_pkg::S_WDATA;
                            end
                            i2c_port_pkg::S_WDATA: begin
                                state_nxt.wr_en = 1'b1;
                                state_nxt.wr_addr = state_r.ptr;
                                state_nxt.wr_data = rx_byte;
                                state_nxt.ptr = 8'(state_r.ptr + i2c_port_pkg::PTR_STEP);
                                state_nxt.after_ack = i2c_port_pkg::S_WDATA;
                            end
                            i2c_port_pkg::S_GC: begin
                                state_nxt.dev_addr = rx_addr;
                                state_nxt.after_ack = i2c_port_pkg::S_IGNORE;
                            end
                            default: begin
                                state_nxt.st = i2c_port_pkg::S_IGNORE;
                            end
                        endcase
                    end
                end
                i2c_port_pkg::S_ACK: begin
                    if (evt.scl_fall) begin
                        state_nxt.sda_oe = 1'b0;
                        state_nxt.bitcnt = i2c_port_pkg::BIT_ZERO;
                        state_nxt.st = state_r.after_ack;
                        if (state_r.after_ack == i2c_port_pkg::S_TX) begin
                            state_nxt.shreg = rd_data;
                            state_nxt.sda_oe = ~rd_data[7];
                        end
                    end
                end
                i2c_port_pkg::S_TX: begin
                    if (evt.scl_rise) begin
                        state_nxt.bitcnt = 4'(state_r.bitcnt + 4'h1);
                    end else if (evt.scl_fall) begin
                        if (state_r.bitcnt == i2c_port_pkg::BIT_DONE) begin
                            // Line let go for the master's answer
                            state_nxt.sda_oe = 1'b0;
                            state_nxt.st = i2c_port_pkg::S_TXACK;
                        end else begin
                            state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
                            state_nxt.sda_oe = ~state_r.shreg[6];
                        end
                    end
                end
                i2c_port_pkg::S_TXACK: begin
                    if (evt.scl_rise) begin
                        if (!sda_s) begin
                            state_nxt.ptr = 8'(state_r.ptr + i2c_port_pkg::PTR_STEP);
                            state_nxt.after_ack = i2c_port_pkg::S_TX;
                            state_nxt.st = i2c_port_pkg::S_ACK;
                        end else begin
                            state_nxt.st = i2c_port_pkg::S_IGNORE;
                        end
                    end
                end
                i2c_port_pkg::S_IDLE, i2c_port_pkg::S_IGNORE: begin
                    state_nxt.sda_oe = 1'b0;
                end
                default: begin
                    state_nxt.st = i2c_port_pkg::S_IDLE;
                    state_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= '{st: i2c_port_pkg::S_IDLE, after_ack: i2c_port_pkg::S_IDLE,
                bitcnt: i2c_port_pkg::BIT_ZERO, shreg: 8'h00,
                ptr: i2c_port_pkg::PTR_RST, dev_addr: DEV_ADDR_DEFAULT,
                sda_oe: 1'b0, wr_en: 1'b0, wr_addr: 8'h00, wr_data: 8'h00};
        end else begin
            state_r <= state_nxt;
        end
    end

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe = state_r.sda_oe;
    assign rd_addr = state_r.ptr;
    assign dev_addr = state_r.dev_addr;
    assign reg_wr.en = state_r.wr_en;
    assign reg_wr.addr = state_r.wr_addr;
    assign reg_wr.data = state_r.wr_data;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence addr_hit_wr;
        state_r.st == i2c_port_pkg::S_ADDR && byte_end && rx_byte == {state_r.dev_addr, i2c_port_pkg::RW_WRITE};
    endsequence

    sequence addr_hit_rd;
        state_r.st == i2c_port_pkg::S_ADDR && byte_end && rx_byte == {state_r.dev_addr, i2c_port_pkg::RW_READ};
    endsequence

    sequence master_ack;
        state_r.st == i2c_port_pkg::S_TXACK && evt.scl_rise && !sda_s;
    endsequence

    sequence foreign_first;
        state_r.st == i2c_port_pkg::S_ADDR && byte_end && rx_addr != state_r.dev_addr
            && rx_byte != i2c_port_pkg::GEN_CALL_BYTE;
    endsequence

    logic [6:0] gc_new;
    assign gc_new = rx_addr;

    a_addr_ack_wr: assert property (addr_hit_wr |-> ##[1:1000] state_r.sda_oe)
        else $error("Own write address not acknowledged");

    a_read_role: assert property (addr_hit_rd |=> state_r.after_ack == i2c_port_pkg::S_TX)
        else $error("Read address did not select transmit");

    a_ptr_load: assert property (state_r.st == i2c_port_pkg::S_REG && byte_end |=> state_r.ptr == $past(rx_byte))
        else $error("Register byte did not load pointer");

    a_no_write_reg: assert property (state_r.st != i2c_port_pkg::S_WDATA |=> !state_r.wr_en)
        else $error("Write issued outside data phase");

    a_wr_advance: assert property (state_r.wr_en |-> state_r.ptr == 8'(state_r.wr_addr + 8'h01))
        else $error("Pointer did not advance after write");

    a_wr_latency: assert property (state_r.st == i2c_port_pkg::S_WDATA && byte_end |-> ##[1:3] state_r.wr_en)
        else $error("Write not started within three clocks");

    a_ptr_wrap: assert property (master_ack ##0 state_r.ptr == i2c_port_pkg::PTR_TOP |=> state_r.ptr == 8'h00)
        else $error("Pointer did not wrap to zero");

    a_cbus_quiet: assert property (state_r.st == i2c_port_pkg::S_ADDR && byte_end &&
        rx_addr == i2c_port_pkg::CBUS_ADDR |=> state_r.st == i2c_port_pkg::S_IGNORE [*2])
        else $error("CBUS address was answered");

    a_ignore_release: assert property (state_r.st == i2c_port_pkg::S_IGNORE |-> !state_r.sda_oe)
        else $error("Data line held while ignoring");

    a_nack_release: assert property (state_r.st == i2c_port_pkg::S_TXACK && evt.scl_rise && sda_s
        |=> !state_r.sda_oe && state_r.st == i2c_port_pkg::S_IGNORE)
        else $error("NACK did not end sending");

    a_tx_load: assert property (state_r.st == i2c_port_pkg::S_ACK && state_r.after_ack == i2c_port_pkg::S_TX
        && evt.scl_fall |=> state_r.shreg == $past(rd_data) && state_r.sda_oe == !state_r.shreg[7])
        else $error("Transmit byte not loaded from pointer");

    a_gc_load: assert property (state_r.st == i2c_port_pkg::S_GC && byte_end |=> state_r.dev_addr == $past(gc_new))
        else $error("General call did not set address");

    a_addr_ack_rd: assert property (addr_hit_rd |-> ##[1:1000] state_r.sda_oe)
        else $error("Own read address not acknowledged");

    a_foreign_quiet: assert property (foreign_first |=> state_r.st == i2c_port_pkg::S_IGNORE)
        else $error("Foreign address was not ignored");

    a_wr_pulse: assert property (state_r.wr_en |=> !state_r.wr_en)
        else $error("Write pulse longer than one cycle");

    a_wr_wrap: assert property (state_r.st == i2c_port_pkg::S_WDATA && byte_end
        && state_r.ptr == i2c_port_pkg::PTR_TOP |=> state_r.ptr == 8'h00)
        else $error("Write pointer did not wrap to zero");

    a_tx_advance: assert property (master_ack |=> state_r.ptr == 8'($past(state_r.ptr) + 8'h01))
        else $error("Master acknowledge did not advance pointer");

    a_start_restart: assert property (evt.start |=> state_r.st == i2c_port_pkg::S_ADDR
        && state_r.bitcnt == i2c_port_pkg::BIT_ZERO && !state_r.sda_oe)
        else $error("Start did not restart address phase");

    a_stop_idle: assert property (evt.stop |=> state_r.st == i2c_port_pkg::S_IDLE && !state_r.sda_oe)
        else $error("Stop did not return to idle");

    a_idle_release: assert property (state_r.st == i2c_port_pkg::S_IDLE |-> !state_r.sda_oe)
        else $error("Data line held while idle");

    // Power-up copy loses only to a general call in the same cycle
    a_nv_load: assert property (nv_load && !(state_r.st == i2c_port_pkg::S_GC && byte_end)
        |=> state_r.dev_addr == $past(nv_dev_addr))
        else $error("Stored address not loaded");

    a_ptr_reset: assert property ($rose(rstn) |-> state_r.ptr == i2c_port_pkg::PTR_RST
        && state_r.dev_addr == DEV_ADDR_DEFAULT)
        else $error("Pointer or address not at reset value");

endmodule : i2c_slave_register_port

// File: tb/i2c_master_model.sv
// Behavioural I2C bus master facing the slave port
`timescale 1ns/100ps
module i2c_master_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl_o,
    output logic sda_o,
    output logic got_valid,
    output logic [7:0] got_byte
);
    localparam int QTR = 10;

    // Lines idle high, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        got_valid = 1'b0;
        got_byte = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : tick

    // Start or repeated start; SDA rises with SCL low, then falls while SCL is high
    task automatic start_cond();
        tick(QTR);
        sda_o = 1'b1;
        tick(QTR);
        scl_o = 1'b1;
        tick(QTR);
        sda_o = 1'b0;
        tick(QTR);
        scl_o = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        tick(QTR);
        sda_o = 1'b0;
        tick(QTR);
        scl_o = 1'b1;
        tick(QTR);
        sda_o = 1'b1;
        tick(QTR);
    endtask : stop_cond

    // Data settles a quarter after the fall, sampled mid high
    task automatic bit_out(input logic b, output logic s);
        tick(QTR);
        sda_o = b;
        tick(QTR);
        scl_o = 1'b1;
        tick(QTR);
        s = sda_line;
        tick(QTR);
        scl_o = 1'b0;
    endtask : bit_out

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i], s);
        end
        bit_out(1'b1, ack);
    endtask : wr_byte

    task automatic read_byte(input logic nack);
        logic [7:0] b;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'b1, s);
            b[i] = s;
        end
        bit_out(nack, s);
        got_byte = b;
        got_valid = 1'b1;
        tick(1);
        got_valid = 1'b0;
    endtask : read_byte
endmodule : i2c_master_model

// File: tb/tb.sv
// Self-checking bench for the I2C slave register port
`timescale 1ns/100ps
module tb;
    logic sys_clk;
    logic rstn;
    logic nv_load;
    logic [6:0] nv_dev_addr;
    logic [7:0] rd_data;
    logic [7:0] rd_addr;
    logic sda_o;
    logic sda_oe;
    logic [6:0] dev_addr;
    i2c_port_pkg::reg_wr_t reg_wr;
    logic m_scl;
    logic m_sda;
    logic got_valid;
    logic [7:0] got_byte;
    wire logic sda_line;
    logic [7:0] mem [256];
    logic [15:0] wr_q [$];
    logic [7:0] rd_q [$];
    logic [7:0] firsts [5] = '{8'h02, 8'h03, 8'h01, 8'hAA, 8'hAB};
    int err_count;
    int checks_done;
    logic ack;
    logic [7:0] ptr;
    logic [6:0] gc_pick;

    // Pull-up: low only while some party pulls
    assign sda_line = m_sda & ~(sda_oe & ~sda_o);
    // Missing registers just return whatever the table holds
    assign rd_data = mem[rd_addr];

    i2c_slave_register_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .scl_i(m_scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .nv_load(nv_load), .nv_dev_addr(nv_dev_addr), .rd_addr(rd_addr),
        .rd_data(rd_data), .reg_wr(reg_wr), .dev_addr(dev_addr));

    i2c_master_model i_master (.sys_clk(sys_clk), .sda_line(sda_line), .scl_o(m_scl), .sda_o(m_sda),
        .got_valid(got_valid), .got_byte(got_byte));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic send(input logic [7:0] b, input logic exp_ack);
        i_master.wr_byte(b, ack);
        check("ack", {15'h0000, exp_ack}, {15'h0000, ack});
    endtask : send

    task automatic wr_xfer(input logic [6:0] a, input logic [7:0] p, input int n, input logic do_stop);
        logic [7:0] d;
        i_master.start_cond();
        send({a, i2c_port_pkg::RW_WRITE}, 1'b0);
        send(p, 1'b0);
        ptr = p;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            wr_q.push_back({ptr, d});
            send(d, 1'b0);
            check("write latency", 16'h0000, 16'(wr_q.size()));
            ptr = ptr + 8'h01;
        end
        if (do_stop) i_master.stop_cond();
    endtask : wr_xfer

    task automatic rd_xfer(input logic [6:0] a, input int n);
        i_master.start_cond();
        send({a, i2c_port_pkg::RW_READ}, 1'b0);
        for (int i = 0; i < n; i++) begin
            rd_q.push_back(mem[ptr]);
            i_master.read_byte(i == n - 1);
            // Only an acknowledged byte moves the pointer on
            if (i < n - 1) ptr = ptr + 8'h01;
        end
        i_master.tick(8);
        check("released", 16'h0000, {15'h0000, sda_oe});
        i_master.stop_cond();
    endtask : rd_xfer

    // Results are matched in arrival order
    always @(posedge sys_clk) begin
        if (reg_wr.en === 1'b1) begin
            check("reg_wr", (wr_q.size() > 0) ? wr_q.pop_front() : 16'hxxxx, {reg_wr.addr, reg_wr.data});
        end
        if (got_valid) begin
            check("read byte", {8'h00, (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx}, {8'h00, got_byte});
        end
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        $display("ERROR watchdog expected 0 seen 1");
        err_count++;
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        nv_load = 1'b0;
        nv_dev_addr = 7'h00;
        err_count = 0;
        checks_done = 0;
        ptr = 8'h00;
        void'($urandom(32'h80d8_a5ce));
        for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
        // One edge over the minimum so the synchroniser fills
        i_master.tick(4);
        rstn = 1'b1;
        i_master.tick(6);
        check("dev_addr", 16'(i2c_port_pkg::DEV_ADDR_RST), 16'(dev_addr));
        rd_xfer(i2c_port_pkg::DEV_ADDR_RST, 2);
        wr_xfer(i2c_port_pkg::DEV_ADDR_RST, 8'hFE, 3, 1'b1);
        wr_xfer(i2c_port_pkg::DEV_ADDR_RST, 8'hFF, 0, 1'b1);
        rd_xfer(i2c_port_pkg::DEV_ADDR_RST, 2);
        wr_xfer(i2c_port_pkg::DEV_ADDR_RST, 8'($urandom), 2, 1'b0);
        rd_xfer(i2c_port_pkg::DEV_ADDR_RST, 3);
        foreach (firsts[i]) begin
            i_master.start_cond();
            send(firsts[i], 1'b1);
            send(8'h5A, 1'b1);
            i_master.stop_cond();
        end
        rd_xfer(i2c_port_pkg::DEV_ADDR_RST, 1);
        // address by general call, never a reserved one
        gc_pick = {3'b011, 4'($urandom)};
        i_master.start_cond();
        send(i2c_port_pkg::GEN_CALL_BYTE, 1'b0);
        send({gc_pick, 1'b1}, 1'b0);
        i_master.stop_cond();
        check("dev_addr", 16'(gc_pick), 16'(dev_addr));
        rd_xfer(gc_pick, 1);
        i_master.start_cond();
        send({i2c_port_pkg::DEV_ADDR_RST, 1'b1}, 1'b1);
        i_master.stop_cond();
        // stored address kept out of reserved ranges
        nv_dev_addr = {2'b10, 5'($urandom)};
        nv_load = 1'b1;
        i_master.tick(1);
        nv_load = 1'b0;
        i_master.tick(1);
        check("dev_addr", 16'(nv_dev_addr), 16'(dev_addr));
        wr_xfer(nv_dev_addr, 8'($urandom), 2, 1'b1);
        // second reset returns pointer and address to their reset values
        rstn = 1'b0;
        i_master.tick(4);
        rstn = 1'b1;
        i_master.tick(6);
        ptr = i2c_port_pkg::PTR_RST;
        rd_xfer(i2c_port_pkg::DEV_ADDR_RST, 1);
        i_master.tick(5);
        check("pending", 16'h0000, 16'(wr_q.size() + rd_q.size()));
        give_verdict();
    end
endmodule : tb
